// *** hw/tcm_pin_filter.sv ***
// Pin input conditioner: three-stage synchroniser plus optional noise filter.
// Assumes pin is asynchronous to pclk; output is a clean level in pclk domain.
`timescale 1ns/100ps
module tcm_pin_filter
    import tcm_pkg::*;
#(
    parameter int SAMPLES = FILTER_SAMPLES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and control
    input  wire logic pin,
    input  wire logic filter_en,
    // Conditioned level
    output logic      level
);
    logic               sync1;
    logic               sync2;
    logic               sync3;
    logic               stable;
    logic [SAMPLES-1:0] history;

    // A change is accepted only once the last two stages agree
    wire next_stable = (sync2 == sync3) ? sync3 : stable;
    wire all_high    = &history;
    wire all_low     = ~|history;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1   <= 1'b0;
            sync2   <= 1'b0;
            sync3   <= 1'b0;
            stable  <= 1'b0;
            history <= '0;
        end else begin
            sync1   <= pin;
            sync2   <= sync1;
            sync3   <= sync2;
            stable  <= next_stable;
            history <= {history[SAMPLES-2:0], stable};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (!filter_en) begin
            level <= stable;
        end else if (all_high || all_low) begin
            level <= history[0];
        end
    end

endmodule // tcm_pin_filter

// *** hw/tcm_pkg.sv ***
// Constants shared by the 16-bit timer control block and its pin filter.
// Assumes register indices are word indices on an APB bus with 32-bit data.
package tcm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL_A     = 8'h80;
    localparam logic [7:0] IDX_CONTROL_B     = 8'h81;
    localparam logic [7:0] IDX_FORCE_COMPARE = 8'h82;
    localparam logic [7:0] IDX_COUNTER_LOW   = 8'h84;
    localparam logic [7:0] IDX_COUNTER_HIGH  = 8'h85;
    localparam logic [7:0] IDX_CAPTURE_LOW   = 8'h86;
    localparam logic [7:0] IDX_CAPTURE_HIGH  = 8'h87;
    localparam logic [7:0] IDX_COMPARE_A_LOW = 8'h88;
    localparam logic [7:0] IDX_COMPARE_A_HIGH = 8'h89;
    localparam logic [7:0] IDX_COMPARE_B_LOW = 8'h8a;
    localparam logic [7:0] IDX_COMPARE_B_HIGH = 8'h8b;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'h91;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Control A fields
    localparam int CA_COM_A_POS = 6;
    localparam int CA_COM_B_POS = 4;
    localparam int CA_WAVE_LO_POS = 0;
    // Control B fields
    localparam int CB_FILTER_POS = 7;
    localparam int CB_EDGE_POS   = 6;
    localparam int CB_WAVE_HI_POS = 3;
    localparam int CB_CLKSEL_POS = 0;
    localparam logic [7:0] CB_WRITE_MASK = 8'hdf;
    // Force compare strobes
    localparam int FC_A_POS = 7;
    localparam int FC_B_POS = 6;
    // Interrupt status / mask layout
    localparam int IRQ_OVF_POS = 0;
    localparam int IRQ_CMPA_POS = 1;
    localparam int IRQ_CMPB_POS = 2;
    localparam int IRQ_CAP_POS = 5;
    localparam logic [7:0] IRQ_USED_MASK = 8'h27;

    // Fixed TOP values
    localparam logic [15:0] TOP_MAX    = 16'hffff;
    localparam logic [15:0] TOP_8BIT   = 16'h00ff;
    localparam logic [15:0] TOP_9BIT   = 16'h01ff;
    localparam logic [15:0] TOP_10BIT  = 16'h03ff;

    // Clock select codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRESCALE_W = 10;

    // Noise filter length in samples
    localparam int FILTER_SAMPLES = 4;

    typedef enum logic [1:0] {
        CAT_NONPWM = 2'b00,
        CAT_FAST   = 2'b01,
        CAT_PC     = 2'b10,
        CAT_PFC    = 2'b11
    } tcm_cat_type;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } tcm_dir_type;

endpackage

// *** hw/tcm_timer16.sv ***
// 16-bit timer: waveform modes, clock select, input capture, force compare,
// byte access through a shared high-byte latch. Assumes an APB master on
// pclk; capture and external clock pins are asynchronous.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Operation
// - Mode is two bits A plus two B
// - Fixed TOP: FFFF, 00FF, 01FF, 03FF
// - Variable TOP from compare A or capture
// - Buffer update and overflow timing per mode
// - Filter needs four equal samples
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture off when capture is TOP
// - Clock select: stop, div 1/8/64/256/1024
// - Codes 6/7: external pin falling/rising
// - Force compare only in non-PWM modes
// - Forced match: no interrupt, no clear
// - Force bits read as zero
// - Byte access via shared high latch
// - Counter write blocks next compare match
module tcm_timer16
    import tcm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic              capture_input_pin,
    input  wire logic              external_clock_pin,
    // Waveform outputs and interrupt
    output logic                   wave_out_a,
    output logic                   wave_out_b,
    output logic                   irq
);
    import tcm_pkg::*;
    logic [7:0]  timer_control_a;
    logic [7:0]  timer_control_b;
    logic [7:0]  temp_high;
    logic [15:0] counter_value;
    logic [15:0] capture_register;
    logic [15:0] compare_buf_a;
    logic [15:0] compare_buf_b;
    logic [15:0] compare_act_a;
    logic [15:0] compare_act_b;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [7:0]  read_high_snap;
    logic [PRESCALE_W-1:0] prescale;
    logic        ext_prev;
    logic        cap_prev;
    logic        match_block;
    tcm_dir_type count_dir;
    // Mode decoding
    function automatic tcm_cat_type mode_cat(input logic [3:0] m);
        case (m)
            4'd1, 4'd2, 4'd3, 4'd10, 4'd11: mode_cat = CAT_PC;
            4'd8, 4'd9:                     mode_cat = CAT_PFC;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15: mode_cat = CAT_FAST;
            default:                        mode_cat = CAT_NONPWM;
        endcase
    endfunction
    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
                                           input logic [15:0] cap);
        case (m)
            4'd1, 4'd5:                top_of = TOP_8BIT;
            4'd2, 4'd6:                top_of = TOP_9BIT;
            4'd3, 4'd7:                top_of = TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15:  top_of = cmp_a;
            4'd8, 4'd10, 4'd12, 4'd14: top_of = cap;
            default:                   top_of = TOP_MAX;
        endcase
    endfunction
    function automatic logic top_is_capture(input logic [3:0] m);
        top_is_capture = (m == 4'd8) || (m == 4'd10) || (m == 4'd12) || (m == 4'd14);
    endfunction
    // Next level of a waveform output for one compare channel
    function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                       input tcm_cat_type cat, input logic match,
                                       input logic bottom, input logic down,
                                       input logic toggle_ok);
        logic res;
        res = cur;
        if (cat == CAT_NONPWM) begin
            if (match) begin
                case (com)
                    2'b01:   res = ~cur;
                    2'b10:   res = 1'b0;
                    2'b11:   res = 1'b1;
                    default: res = cur;
                endcase
            end
        end else if (com == 2'b01) begin
            if (match && toggle_ok) begin
                res = ~cur;
            end
        end else if (com[1]) begin
            if (cat == CAT_FAST) begin
                if (match) begin
                    res = com[0];
                end else if (bottom) begin
                    res = ~com[0];
                end
            end else if (match) begin
                res = com[0] ^ down;
            end
        end
        wave_next = res;
    endfunction
    // Mode and configuration fields
    wire [3:0]  wave_mode_field = {timer_control_b[CB_WAVE_HI_POS+1:CB_WAVE_HI_POS],
                                   timer_control_a[CA_WAVE_LO_POS+1:CA_WAVE_LO_POS]};
    wire [1:0]  com_a       = timer_control_a[CA_COM_A_POS+1:CA_COM_A_POS];
    wire [1:0]  com_b       = timer_control_a[CA_COM_B_POS+1:CA_COM_B_POS];
    wire [2:0]  clock_sel   = timer_control_b[CB_CLKSEL_POS+2:CB_CLKSEL_POS];
    wire        edge_select = timer_control_b[CB_EDGE_POS];
    wire        filter_en   = timer_control_b[CB_FILTER_POS];
    tcm_cat_type cat;
    assign cat = mode_cat(wave_mode_field);
    wire [15:0] top_value   = top_of(wave_mode_field, compare_act_a, capture_register);
    wire        cap_is_top  = top_is_capture(wave_mode_field);
    // Pin conditioning
    logic cap_level;
    logic ext_level;
    tcm_pin_filter #(.SAMPLES(FILTER_SAMPLES)) u_cap_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (capture_input_pin),
        .filter_en (filter_en),
        .level     (cap_level)
    );
    tcm_pin_filter #(.SAMPLES(FILTER_SAMPLES)) u_ext_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (external_clock_pin),
        .filter_en (1'b0),
        .level     (ext_level)
    );
    // Timer clock enable from prescaler or external pin
    wire ext_rise = ext_level & ~ext_prev;
    wire ext_fall = ~ext_level & ext_prev;
    logic tick;
    always_comb begin
        case (clock_sel)
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = &prescale[2:0];
            CS_DIV64:    tick = &prescale[5:0];
            CS_DIV256:   tick = &prescale[7:0];
            CS_DIV1024:  tick = &prescale[9:0];
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
            default:     tick = 1'b0;
        endcase
    end
    // Count sequence
    wire is_updown   = (cat == CAT_PC) || (cat == CAT_PFC);
    wire at_top      = is_updown || (cat == CAT_FAST) ? (counter_value >= top_value)
                                                      : (counter_value == top_value);
    wire at_bottom   = (counter_value == RST_WORD);
    wire going_down  = (count_dir == DIR_DOWN);
    wire turn_down   = is_updown && !going_down && at_top;
    wire turn_up     = is_updown && going_down && at_bottom;
    wire count_down  = is_updown && (going_down ? !at_bottom : at_top);
    wire wrap        = !is_updown && at_top;
    wire [15:0] next_count = wrap       ? RST_WORD :
                             count_down ? counter_value - 16'h0001 :
                                          counter_value + 16'h0001;
    // Buffer update and overflow points
    wire update_point   = (cat == CAT_NONPWM) ? 1'b1 :
                          (cat == CAT_FAST)   ? (tick && wrap) :
                          (cat == CAT_PC)     ? (tick && turn_down) : (tick && turn_up);
    wire overflow_point = (cat == CAT_NONPWM) ? (tick && (counter_value == TOP_MAX)) :
                          (cat == CAT_FAST)   ? (tick && wrap) : (tick && turn_up);
    // Compare matches; a counter write masks the next timer clock
    wire match_a     = tick && !match_block && (counter_value == compare_act_a);
    wire match_b     = tick && !match_block && (counter_value == compare_act_b);
    wire bottom_evt  = tick && wrap;
    // Capture edge detection
    wire cap_edge    = edge_select ? (cap_level & ~cap_prev) : (~cap_level & cap_prev);
    wire cap_event   = cap_edge && !cap_is_top;
    wire cap_top_evt = cap_is_top && tick && at_top;
    // APB decode
    wire [7:0] idx       = paddr[9:2];
    wire       addr_ok   = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    wire       sel_ca    = addr_ok && (idx == IDX_CONTROL_A);
    wire       sel_cb    = addr_ok && (idx == IDX_CONTROL_B);
    wire       sel_fc    = addr_ok && (idx == IDX_FORCE_COMPARE);
    wire       sel_cnt_l = addr_ok && (idx == IDX_COUNTER_LOW);
    wire       sel_cnt_h = addr_ok && (idx == IDX_COUNTER_HIGH);
    wire       sel_cap_l = addr_ok && (idx == IDX_CAPTURE_LOW);
    wire       sel_cap_h = addr_ok && (idx == IDX_CAPTURE_HIGH);
    wire       sel_ca_l  = addr_ok && (idx == IDX_COMPARE_A_LOW);
    wire       sel_ca_h  = addr_ok && (idx == IDX_COMPARE_A_HIGH);
    wire       sel_cb_l  = addr_ok && (idx == IDX_COMPARE_B_LOW);
    wire       sel_cb_h  = addr_ok && (idx == IDX_COMPARE_B_HIGH);
    wire       sel_ist   = addr_ok && (idx == IDX_IRQ_STATUS);
    wire       sel_imsk  = addr_ok && (idx == IDX_IRQ_MASK);
    wire       sel_low   = sel_cnt_l || sel_cap_l || sel_ca_l || sel_cb_l;
    wire       sel_high  = sel_cnt_h || sel_cap_h || sel_ca_h || sel_cb_h;
    wire       mapped    = sel_ca || sel_cb || sel_fc || sel_low || sel_high || sel_ist
                           || sel_imsk;
    wire       setup     = psel && !penable;
    wire       access    = psel && penable && pready;
    wire       wr_acc    = access && pwrite && !pslverr;
    wire       rd_acc    = access && !pwrite && !pslverr;
    wire [7:0] wbyte     = pwdata[7:0];
    wire [15:0] wword    = {temp_high, wbyte};
    // Read data; high bytes come from the latch filled by the low-byte read
    wire [15:0] rd_word = sel_cnt_l ? counter_value :
                          sel_cap_l ? capture_register :
                          sel_ca_l  ? compare_buf_a : compare_buf_b;
    wire [7:0] rd_byte = sel_ca    ? timer_control_a :
                         sel_cb    ? (timer_control_b & CB_WRITE_MASK) :
                         sel_low   ? rd_word[7:0] :
                         sel_high  ? temp_high :
                         sel_ist   ? irq_status :
                         sel_imsk  ? irq_mask : 8'h00;
    // Force strobes act only in non-PWM modes and raise no flag
    wire force_a = wr_acc && sel_fc && wbyte[FC_A_POS] && (cat == CAT_NONPWM);
    wire force_b = wr_acc && sel_fc && wbyte[FC_B_POS] && (cat == CAT_NONPWM);
    // Event collection; set wins over read-clear of the same bit
    logic [7:0] events;
    always_comb begin
        events               = 8'h00;
        events[IRQ_OVF_POS]  = overflow_point;
        events[IRQ_CMPA_POS] = match_a;
        events[IRQ_CMPB_POS] = match_b;
        events[IRQ_CAP_POS]  = cap_event || cap_top_evt;
    end
    wire [7:0] read_clear = (rd_acc && sel_ist) ? prdata[7:0] : 8'h00;
    wire [7:0] next_status = (irq_status & ~read_clear) | events;
    // APB response: one wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            prdata         <= 32'h00000000;
            read_high_snap <= RST_BYTE;
        end else begin
            pready         <= setup;
            pslverr        <= setup && !mapped;
            read_high_snap <= setup ? rd_word[15:8] : read_high_snap;
            prdata         <= setup ? {24'h000000, rd_byte} : prdata;
        end
    end
    // Control registers and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_a <= RST_BYTE;
            timer_control_b <= RST_BYTE;
            irq_mask        <= RST_BYTE;
            irq_status      <= RST_BYTE;
            irq             <= 1'b0;
        end else begin
            if (wr_acc && sel_ca) begin
                timer_control_a <= wbyte;
            end
            if (wr_acc && sel_cb) begin
                timer_control_b <= wbyte & CB_WRITE_MASK;
            end
            if (wr_acc && sel_imsk) begin
                irq_mask <= wbyte & IRQ_USED_MASK;
            end
            irq_status <= next_status;
            irq        <= |(next_status & irq_mask);
        end
    end
    // Shared high-byte latch: filled by high writes and low reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_high <= RST_BYTE;
        end else if (wr_acc && sel_high) begin
            temp_high <= wbyte;
        end else if (rd_acc && sel_low) begin
            temp_high <= read_high_snap;
        end
    end
    // Counter and direction; software write takes priority over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= RST_WORD;
            count_dir     <= DIR_UP;
            match_block   <= 1'b0;
        end else if (wr_acc && sel_cnt_l) begin
            counter_value <= wword;
            match_block   <= 1'b1;
        end else if (tick) begin
            counter_value <= next_count;
            match_block   <= 1'b0;
            if (turn_down) begin
                count_dir <= DIR_DOWN;
            end else if (turn_up || !is_updown) begin
                count_dir <= DIR_UP;
            end
        end
    end
    // Compare buffers and their active copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_buf_a <= RST_WORD;
            compare_buf_b <= RST_WORD;
            compare_act_a <= RST_WORD;
            compare_act_b <= RST_WORD;
        end else begin
            if (wr_acc && sel_ca_l) begin
                compare_buf_a <= wword;
            end
            if (wr_acc && sel_cb_l) begin
                compare_buf_b <= wword;
            end
            if (update_point) begin
                compare_act_a <= compare_buf_a;
                compare_act_b <= compare_buf_b;
            end
        end
    end
    // Capture register: hardware capture, or software write in any mode; capture wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_register <= RST_WORD;
        end else if (cap_event) begin
            capture_register <= counter_value;
        end else if (wr_acc && sel_cap_l) begin
            capture_register <= wword;
        end
    end
    // Edge history and prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
            ext_prev <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            prescale <= prescale + 1'b1;
            ext_prev <= ext_level;
            cap_prev <= cap_level;
        end
    end
    // Waveform outputs; forced matches count as matches for the output only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end else begin
            wave_out_a <= wave_next(wave_out_a, com_a, cat, match_a || force_a, bottom_evt,
                                    going_down, (wave_mode_field == 4'd9)
                                    || (wave_mode_field == 4'd11) || (wave_mode_field == 4'd14)
                                    || (wave_mode_field == 4'd15));
            wave_out_b <= wave_next(wave_out_b, com_b, cat, match_b || force_b, bottom_evt,
                                    going_down, 1'b0);
        end
    end

endmodule // tcm_timer16

// *** tb/tcm_timer16_chk.sv ***
// Port checker for the 16-bit timer block.
// Assumes it is bound to tcm_timer16 and sees only its ports.
`timescale 1ns/100ps
module tcm_timer16_chk #(
    parameter int ADDR_W = 12
) (
    // APB side
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Interrupt
    input wire logic              irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_has_cause: assert property ($rose(pready) |-> $past(psel && !penable))
        else $error("pready without setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_misaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_force_reads_zero: assert property (pready && !pwrite && paddr == 12'h208
        |-> prdata[7:0] == 8'h00)
        else $error("force strobes read nonzero");
    a_mask_off_quiet: assert property (pready && pwrite && paddr == 12'h244
        && pwdata[7:0] == 8'h00 |-> ##2 !irq)
        else $error("irq high with mask cleared");
endmodule // tcm_timer16_chk

bind tcm_timer16 tcm_timer16_chk #(.ADDR_W(ADDR_W)) tcm_timer16_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

// *** tb/tcm_timer16_tb.sv ***
// Bench for the 16-bit timer: registers, counter bytes, external clock, capture.
// Assumes a wait-free APB slave and pins sampled on pclk.
`timescale 1ns/100ps
module tcm_timer16_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cap_pin = 1'b0;
    logic        ext_pin = 1'b0;
    logic        irq;
    logic        wave_a;
    logic        wave_b;
    logic [7:0]  q;
    logic        err;
    int          mismatches = 0;
    int          total_checks = 0;
    logic [7:0]  cs_codes [3] = '{8'h07, 8'h06, 8'h00};
    always #25 pclk = ~pclk;
    tcm_timer16 tcm_timer16_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(cap_pin), .external_clock_pin(ext_pin),
        .wave_out_a(wave_a), .wave_out_b(wave_b), .irq(irq));
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // Request held from setup until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(n, e, q);
    endtask
    task automatic ext_pulses(input int n);
        repeat (n) begin
            ext_pin <= 1'b1;
            ticks(8);
            ext_pin <= 1'b0;
            ticks(8);
        end
    endtask
    initial begin
        ticks(20000);
        mismatches++;
        test_done();
    end
    initial begin
        ticks(10);
        presetn <= 1'b1;
        rd("control_b", 12'h204, 8'h00);
        rd("counter_low", 12'h210, 8'h00);
        apb(1'b1, 12'h204, 8'hff);
        rd("control_b", 12'h204, 8'hdf);
        apb(1'b1, 12'h208, 8'hc0);
        rd("force", 12'h208, 8'h00);
        apb(1'b0, 12'h202, 8'h00);
        chk("slverr", 8'h01, {7'h0, err});
        $display("test registers done");
        apb(1'b1, 12'h204, 8'h00);
        apb(1'b1, 12'h214, 8'h12);
        apb(1'b1, 12'h210, 8'h34);
        rd("counter_low", 12'h210, 8'h34);
        rd("counter_high", 12'h214, 8'h12);
        // Rising, falling, then stopped: two ticks each for the first two
        foreach (cs_codes[i]) begin
            apb(1'b1, 12'h204, cs_codes[i]);
            ext_pulses(2);
        end
        rd("counter_low", 12'h210, 8'h38);
        $display("test counter done");
        apb(1'b1, 12'h244, 8'h20);
        apb(1'b1, 12'h204, 8'h40);
        cap_pin <= 1'b1;
        ticks(12);
        chk("irq", 8'h01, {7'h0, irq});
        rd("capture_low", 12'h218, 8'h38);
        rd("capture_high", 12'h21c, 8'h12);
        rd("status", 12'h240, 8'h20);
        rd("status", 12'h240, 8'h00);
        ticks(2);
        chk("irq", 8'h00, {7'h0, irq});
        apb(1'b1, 12'h204, 8'h00);
        apb(1'b1, 12'h244, 8'h00);
        apb(1'b1, 12'h214, 8'h0a);
        apb(1'b1, 12'h210, 8'hbc);
        cap_pin <= 1'b0;
        ticks(12);
        chk("irq", 8'h00, {7'h0, irq});
        rd("capture_low", 12'h218, 8'hbc);
        rd("capture_high", 12'h21c, 8'h0a);
        rd("status", 12'h240, 8'h20);
        $display("test capture done");
        // Short glitch must be filtered out, a steady level must pass
        apb(1'b1, 12'h204, 8'hc0);
        cap_pin <= 1'b1;
        ticks(2);
        cap_pin <= 1'b0;
        ticks(16);
        rd("status", 12'h240, 8'h00);
        cap_pin <= 1'b1;
        ticks(20);
        rd("status", 12'h240, 8'h20);
        apb(1'b1, 12'h214, 8'h07);
        apb(1'b1, 12'h210, 8'h77);
        apb(1'b1, 12'h204, 8'h18);
        cap_pin <= 1'b0;
        ticks(16);
        rd("capture_low", 12'h218, 8'hbc);
        $display("test filter done");
        // Undivided clock runs for exactly three edges between the two writes
        apb(1'b1, 12'h204, 8'h19);
        apb(1'b1, 12'h204, 8'h18);
        rd("counter_low", 12'h210, 8'h7a);
        apb(1'b1, 12'h200, 8'h70);
        apb(1'b1, 12'h204, 8'h08);
        apb(1'b1, 12'h208, 8'hc0);
        ticks(1);
        chk("wave_a", 8'h01, {7'h0, wave_a});
        chk("wave_b", 8'h01, {7'h0, wave_b});
        rd("counter_low", 12'h210, 8'h7a);
        rd("status", 12'h240, 8'h00);
        // Fast PWM: the strobe must leave the toggling output alone
        apb(1'b1, 12'h200, 8'h71);
        apb(1'b1, 12'h208, 8'hc0);
        ticks(1);
        chk("wave_a", 8'h01, {7'h0, wave_a});
        $display("test force done");
        test_done();
    end
endmodule // tcm_timer16_tb
